// >>> rtl/mpc_regs.svh
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH
`define MPC_ADDR_PDM1_LO 8'h20
`define MPC_ADDR_PDM1_HI 8'h21
`define MPC_ADDR_PDM2_LO 8'h23
`define MPC_ADDR_PDM2_HI 8'h24
`define MPC_ADDR_PD_CTRL 8'h26
`define MPC_ADDR_PERF_LO 8'h39
`define MPC_ADDR_PERF_MID 8'h3a
`define MPC_ADDR_IN_COUPLE 8'h4f
`define MPC_ADDR_SREF_CTRL 8'h53
`define MPC_ADDR_SREF_MAN 8'h54
`define MPC_ADDR_REG_PD 8'h55
`define MPC_ADDR_PERF_HI 8'h56
`define MPC_BIT_FULL_PD 7
`define MPC_BIT_IGN_PIN 6
`define MPC_BIT_SET_CHOICE 5
`define MPC_BIT_PERF_LO_H 7
`define MPC_BIT_PERF_LO_L 6
`define MPC_BIT_PERF_MID 6
`define MPC_BIT_PERF_HI 2
`define MPC_BIT_DC_BIAS 0
`define MPC_BIT_SREF_IGN 6
`define MPC_BIT_SREF_HCM 1
`define MPC_BIT_SREF_LVL 0
`define MPC_BIT_SREF_MAN 7
`define MPC_BIT_REG_PD 4
`define MPC_MASK_PD_CTRL 8'he0
`define MPC_MASK_PERF_LO 8'hc0
`define MPC_MASK_PERF_MID 8'h40
`define MPC_MASK_IN_COUPLE 8'h01
`define MPC_MASK_SREF_CTRL 8'h43
`define MPC_MASK_SREF_MAN 8'h80
`define MPC_MASK_REG_PD 8'h10
`define MPC_MASK_PERF_HI 8'h04
`define MPC_MASK_PDM_LO 8'hff
`define MPC_MASK_PDM_HI 8'hf0
`define MPC_RESET_VAL 8'h00
`endif

// >>> rtl/mpc_pkg.sv
package mpc_pkg;
   // Power-down mask contents, two bytes per set
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } mpc_pd_mask_t;
   // Control outputs toward the analog and clocking blocks
   typedef struct packed {
      logic full_chip_powerdown;
      logic ignore_powerdown_pin;
      logic powerdown_set_choice;
      logic [3:0] performance_setting_field;
      logic analog_input_dc_bias_on;
      logic sync_reference_ignore;
      logic sync_reference_high_cm_on;
      logic sync_reference_manual_on;
      logic sync_reference_level;
      logic register_driven_powerdown;
   } mpc_ctrl_t;
endpackage

// >>> rtl/mpc_master_page.sv
// Notes on behaviour
// - Global power-down bit 1 forces full power-down; 0 normal.
// - Pin-override bit 1 ignores the external power-down pin.
// - Mask-select 0 picks first mask, 1 picks second.
// - Perf bits 1:0 at 39h bits 7-6; bit 2 at 3Ah bit 6.
// - Bit 0 of 4Fh selects dc-coupling input bias.
// - SYSREF-ignore bit 1 discards external SYSREF entirely.
// - Bit 1 of 53h enables high SYSREF common-mode support.
// - 54h bit 7 enables manual SYSREF, level from 53h bit 0.
// - 55h bit 4 powers down blocks of the selected mask.
// - First mask at 20h/21h, second mask at 23h/24h.
// - Perf bit 3 lives at 56h bit 2.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
module mpc_master_page (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic powerdown_pin,
   input wire logic sync_reference_in,
   output mpc_pkg::mpc_ctrl_t ctrl,
   output mpc_pkg::mpc_pd_mask_t active_pd_mask,
   output logic device_powerdown,
   output logic sync_reference_out
);
   import mpc_pkg::*;

   logic [7:0] pdm1_lo, pdm1_hi, pdm2_lo, pdm2_hi;
   logic [7:0] pd_ctrl, perf_lo, perf_mid, in_couple;
   logic [7:0] sref_ctrl, sref_man, reg_pd, perf_hi;
   logic [7:0] next_pdm1_lo, next_pdm1_hi, next_pdm2_lo, next_pdm2_hi;
   logic [7:0] next_pd_ctrl, next_perf_lo, next_perf_mid, next_in_couple;
   logic [7:0] next_sref_ctrl, next_sref_man, next_reg_pd, next_perf_hi;
   logic [7:0] next_rdata;
   logic pin_s1, pin_s2, sref_s1, sref_s2;
   mpc_ctrl_t next_ctrl;
   mpc_pd_mask_t next_mask;
   logic next_dev_pd, next_sref_out;

   // Keeps only implemented bits; reserved bits never store
   function automatic logic [7:0] wr_field(input logic [7:0] d,
                                           input logic [7:0] m);
      wr_field = d & m;
   endfunction

   // Register write decode
   always_comb begin
      next_pdm1_lo = pdm1_lo;
      next_pdm1_hi = pdm1_hi;
      next_pdm2_lo = pdm2_lo;
      next_pdm2_hi = pdm2_hi;
      next_pd_ctrl = pd_ctrl;
      next_perf_lo = perf_lo;
      next_perf_mid = perf_mid;
      next_in_couple = in_couple;
      next_sref_ctrl = sref_ctrl;
      next_sref_man = sref_man;
      next_reg_pd = reg_pd;
      next_perf_hi = perf_hi;
      if (wr_en) begin
         unique case (addr)
            `MPC_ADDR_PDM1_LO: begin
               next_pdm1_lo = wr_field(wdata, `MPC_MASK_PDM_LO);
            end
            `MPC_ADDR_PDM1_HI: begin
               next_pdm1_hi = wr_field(wdata, `MPC_MASK_PDM_HI);
            end
            `MPC_ADDR_PDM2_LO: begin
               next_pdm2_lo = wr_field(wdata, `MPC_MASK_PDM_LO);
            end
            `MPC_ADDR_PDM2_HI: begin
               next_pdm2_hi = wr_field(wdata, `MPC_MASK_PDM_HI);
            end
            `MPC_ADDR_PD_CTRL: begin
               // Global bit accepted as written; ordering is the host's
               next_pd_ctrl = wr_field(wdata, `MPC_MASK_PD_CTRL);
            end
            `MPC_ADDR_PERF_LO: begin
               next_perf_lo = wr_field(wdata, `MPC_MASK_PERF_LO);
            end
            `MPC_ADDR_PERF_MID: begin
               next_perf_mid = wr_field(wdata, `MPC_MASK_PERF_MID);
            end
            `MPC_ADDR_IN_COUPLE: begin
               next_in_couple = wr_field(wdata, `MPC_MASK_IN_COUPLE);
            end
            `MPC_ADDR_SREF_CTRL: begin
               next_sref_ctrl = wr_field(wdata, `MPC_MASK_SREF_CTRL);
            end
            `MPC_ADDR_SREF_MAN: begin
               next_sref_man = wr_field(wdata, `MPC_MASK_SREF_MAN);
            end
            `MPC_ADDR_REG_PD: begin
               next_reg_pd = wr_field(wdata, `MPC_MASK_REG_PD);
            end
            `MPC_ADDR_PERF_HI: begin
               next_perf_hi = wr_field(wdata, `MPC_MASK_PERF_HI);
            end
            default: begin
               // Unmapped address: write ignored
            end
         endcase
      end
   end

   // Readback; write-only bits and unmapped addresses read zero
   always_comb begin
      unique case (addr)
         `MPC_ADDR_PDM1_LO: next_rdata = pdm1_lo;
         `MPC_ADDR_PDM1_HI: next_rdata = pdm1_hi;
         `MPC_ADDR_PDM2_LO: next_rdata = pdm2_lo;
         `MPC_ADDR_PDM2_HI: next_rdata = pdm2_hi;
         `MPC_ADDR_PD_CTRL: next_rdata = pd_ctrl;
         `MPC_ADDR_PERF_LO: next_rdata = perf_lo;
         `MPC_ADDR_PERF_MID: next_rdata = perf_mid;
         `MPC_ADDR_IN_COUPLE: next_rdata = in_couple;
         `MPC_ADDR_SREF_CTRL: next_rdata = sref_ctrl;
         `MPC_ADDR_SREF_MAN: next_rdata = sref_man;
         `MPC_ADDR_REG_PD: next_rdata = reg_pd;
         default: next_rdata = `MPC_RESET_VAL;
      endcase
   end

   // Control decode from stored bits and synchronised pins
   always_comb begin
      next_ctrl.full_chip_powerdown = pd_ctrl[`MPC_BIT_FULL_PD];
      next_ctrl.ignore_powerdown_pin = pd_ctrl[`MPC_BIT_IGN_PIN];
      next_ctrl.powerdown_set_choice = pd_ctrl[`MPC_BIT_SET_CHOICE];
      next_ctrl.performance_setting_field = {perf_hi[`MPC_BIT_PERF_HI],
         perf_mid[`MPC_BIT_PERF_MID],
         perf_lo[`MPC_BIT_PERF_LO_H:`MPC_BIT_PERF_LO_L]};
      next_ctrl.analog_input_dc_bias_on = in_couple[`MPC_BIT_DC_BIAS];
      next_ctrl.sync_reference_ignore = sref_ctrl[`MPC_BIT_SREF_IGN];
      next_ctrl.sync_reference_high_cm_on =
         sref_ctrl[`MPC_BIT_SREF_HCM];
      next_ctrl.sync_reference_manual_on = sref_man[`MPC_BIT_SREF_MAN];
      next_ctrl.sync_reference_level = sref_ctrl[`MPC_BIT_SREF_LVL];
      next_ctrl.register_driven_powerdown = reg_pd[`MPC_BIT_REG_PD];
      // Mask shown only while register power-down is on
      if (!reg_pd[`MPC_BIT_REG_PD]) begin
         next_mask = '0;
      end else if (pd_ctrl[`MPC_BIT_SET_CHOICE]) begin
         next_mask = '{hi: pdm2_hi, lo: pdm2_lo};
      end else begin
         next_mask = '{hi: pdm1_hi, lo: pdm1_lo};
      end
      // Pin counts only when not overridden
      next_dev_pd = pd_ctrl[`MPC_BIT_FULL_PD] |
         (~pd_ctrl[`MPC_BIT_IGN_PIN] & pin_s2);
      // Manual level wins over input, ignore blanks input
      if (sref_man[`MPC_BIT_SREF_MAN]) begin
         next_sref_out = sref_ctrl[`MPC_BIT_SREF_LVL];
      end else begin
         next_sref_out = ~sref_ctrl[`MPC_BIT_SREF_IGN] & sref_s2;
      end
   end

   // State registers; clock enable freezes everything except synchronous reset
   always_ff @(posedge clk) begin
      if (srst) begin
         pdm1_lo <= `MPC_RESET_VAL;
         pdm1_hi <= `MPC_RESET_VAL;
         pdm2_lo <= `MPC_RESET_VAL;
         pdm2_hi <= `MPC_RESET_VAL;
         pd_ctrl <= `MPC_RESET_VAL;
         perf_lo <= `MPC_RESET_VAL;
         perf_mid <= `MPC_RESET_VAL;
         in_couple <= `MPC_RESET_VAL;
         sref_ctrl <= `MPC_RESET_VAL;
         sref_man <= `MPC_RESET_VAL;
         reg_pd <= `MPC_RESET_VAL;
         perf_hi <= `MPC_RESET_VAL;
         rdata <= `MPC_RESET_VAL;
         ctrl <= '0;
         active_pd_mask <= '0;
         device_powerdown <= 1'b0;
         sync_reference_out <= 1'b0;
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         sref_s1 <= 1'b0;
         sref_s2 <= 1'b0;
      end else if (ce) begin
         pdm1_lo <= next_pdm1_lo;
         pdm1_hi <= next_pdm1_hi;
         pdm2_lo <= next_pdm2_lo;
         pdm2_hi <= next_pdm2_hi;
         pd_ctrl <= next_pd_ctrl;
         perf_lo <= next_perf_lo;
         perf_mid <= next_perf_mid;
         in_couple <= next_in_couple;
         sref_ctrl <= next_sref_ctrl;
         sref_man <= next_sref_man;
         reg_pd <= next_reg_pd;
         perf_hi <= next_perf_hi;
         rdata <= next_rdata;
         ctrl <= next_ctrl;
         active_pd_mask <= next_mask;
         device_powerdown <= next_dev_pd;
         sync_reference_out <= next_sref_out;
         pin_s1 <= powerdown_pin;
         pin_s2 <= pin_s1;
         sref_s1 <= sync_reference_in;
         sref_s2 <= sref_s1;
      end
   end

   // Checks
   // Global bit taken, then one enabled edge to decode it
   sequence s_pd_written;
      ce && wr_en && addr == `MPC_ADDR_PD_CTRL && wdata[`MPC_BIT_FULL_PD];
   endsequence
   sequence s_decode_step;
      ce;
   endsequence
   property p_full_pd;
      @(posedge clk) disable iff (srst)
         s_pd_written ##1 s_decode_step |=> device_powerdown;
   endproperty
   a_full_pd: assert property (p_full_pd)
      else $error("full power-down not reached");
   property p_pin_ignored;
      @(posedge clk) disable iff (srst)
         ce && !ctrl.full_chip_powerdown && ctrl.ignore_powerdown_pin
         && $stable(pd_ctrl) |=> !device_powerdown;
   endproperty
   a_pin_ignored: assert property (p_pin_ignored)
      else $error("pin acted while overridden");
   property p_manual_sref;
      @(posedge clk) disable iff (srst)
         ce && sref_man[`MPC_BIT_SREF_MAN] |=>
         sync_reference_out == $past(sref_ctrl[`MPC_BIT_SREF_LVL]);
   endproperty
   a_manual_sref: assert property (p_manual_sref)
      else $error("manual level not driven");
   property p_sref_ignore;
      @(posedge clk) disable iff (srst)
         ce && !sref_man[`MPC_BIT_SREF_MAN] && sref_ctrl[`MPC_BIT_SREF_IGN]
         |=> !sync_reference_out;
   endproperty
   a_sref_ignore: assert property (p_sref_ignore)
      else $error("masked input passed");
   property p_mask_pick;
      @(posedge clk) disable iff (srst)
         ce && reg_pd[`MPC_BIT_REG_PD] && pd_ctrl[`MPC_BIT_SET_CHOICE]
         |=> active_pd_mask.lo == $past(pdm2_lo);
   endproperty
   a_mask_pick: assert property (p_mask_pick)
      else $error("wrong mask selected");
   property p_no_reg_pd;
      @(posedge clk) disable iff (srst)
         ce && !reg_pd[`MPC_BIT_REG_PD] |=> active_pd_mask == '0;
   endproperty
   a_no_reg_pd: assert property (p_no_reg_pd)
      else $error("mask active without power-down");
   property p_perf;
      @(posedge clk) disable iff (srst)
         ce |=> ctrl.performance_setting_field[3] ==
         $past(perf_hi[`MPC_BIT_PERF_HI]);
   endproperty
   a_perf: assert property (p_perf)
      else $error("perf bit 3 misplaced");
   property p_reset_zero;
      @(posedge clk) srst |=> pd_ctrl == '0 && sref_man == '0
         && !device_powerdown;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("reset value not zero");
endmodule
`default_nettype wire

// >>> dv/mpc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"
// Register host: drives after falling edges, taken at the rising edge
module mpc_host (
   input wire logic clk,
   output logic ce,
   output logic wr_en,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   // Idle levels at time zero
   initial begin
      ce = 1'b1;
      wr_en = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end
   // Writable bits per address; other bits leave as zero, unmapped addresses pass all bits
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         `MPC_ADDR_PD_CTRL: return `MPC_MASK_PD_CTRL;
         `MPC_ADDR_PERF_LO: return `MPC_MASK_PERF_LO;
         `MPC_ADDR_PERF_MID: return `MPC_MASK_PERF_MID;
         `MPC_ADDR_PERF_HI: return `MPC_MASK_PERF_HI;
         `MPC_ADDR_IN_COUPLE: return `MPC_MASK_IN_COUPLE;
         `MPC_ADDR_SREF_CTRL: return `MPC_MASK_SREF_CTRL;
         `MPC_ADDR_SREF_MAN: return `MPC_MASK_SREF_MAN;
         `MPC_ADDR_REG_PD: return `MPC_MASK_REG_PD;
         `MPC_ADDR_PDM1_HI, `MPC_ADDR_PDM2_HI: return `MPC_MASK_PDM_HI;
         default: return 8'hff;
      endcase
   endfunction
   // One write; raw lets a refusal test set reserved bits on purpose
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
      @(negedge clk);
      addr = a;
      wdata = raw ? d : (d & wmask(a));
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      wdata = ~wdata; // Released data must not look valid
   endtask
   // Clock enable change, off the sampling edge
   task automatic set_ce(input bit v);
      @(negedge clk);
      ce = v;
   endtask
   // Read data is registered, so it is taken one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      d = rdata;
   endtask
   // Override goes in first whenever the global bit is to be set
   task automatic set_pd(input bit g, input bit ov, input bit sel);
      if (g) wr(`MPC_ADDR_PD_CTRL, {1'b0, 1'b1, sel, 5'h00}, 1'b0);
      wr(`MPC_ADDR_PD_CTRL, {g, ov | g, sel, 5'h00}, 1'b0);
   endtask
   // All four field bits always written, one address after another
   task automatic set_perf(input logic [3:0] v);
      wr(`MPC_ADDR_PERF_LO, {v[1:0], 6'h00}, 1'b0);
      wr(`MPC_ADDR_PERF_MID, {1'b0, v[2], 6'h00}, 1'b0);
      wr(`MPC_ADDR_PERF_HI, {5'h00, v[3], 2'h0}, 1'b0);
   endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mpc_pkg::*;
   logic clk, srst, ce, wr_en, pin, sref, dpd, sout;
   logic [7:0] addr, wdata, rdata;
   mpc_ctrl_t ctrl;
   mpc_pd_mask_t pdm;
   int failures, num_checks, cycles;
   logic [7:0] regs [11] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h26, 8'h39,
      8'h3a, 8'h4f, 8'h53, 8'h54, 8'h55};
   mpc_master_page mpc_master_page_i (.clk(clk), .srst(srst), .ce(ce),
      .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata),
      .powerdown_pin(pin), .sync_reference_in(sref), .ctrl(ctrl),
      .active_pd_mask(pdm), .device_powerdown(dpd),
      .sync_reference_out(sout));
   mpc_host mpc_host_i (.clk(clk), .ce(ce), .wr_en(wr_en), .addr(addr),
      .wdata(wdata), .rdata(rdata));
   // 20 MHz clock
   initial clk = 1'b0;
   always #25 clk = ~clk;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      mpc_host_i.rd(a, d);
      chk(16'(d), 16'(e));
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Hang guard, well above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      srst = 1'b1;
      pin = 1'b0;
      sref = 1'b0;
      wt(3);
      srst = 1'b0;
      foreach (regs[i]) rchk(regs[i], 8'h00);
      chk(16'(ctrl), 16'h0000);
      // Reserved bits and unmapped places read zero
      mpc_host_i.wr(8'h26, 8'hff, 1'b1);
      mpc_host_i.wr(8'h30, 8'hff, 1'b1);
      rchk(8'h26, 8'he0);
      rchk(8'h30, 8'h00);
      mpc_host_i.set_pd(1'b0, 1'b0, 1'b0);
      mpc_host_i.set_pd(1'b1, 1'b1, 1'b0);
      wt(2);
      chk(ctrl.full_chip_powerdown, 1'b1);
      chk(dpd, 1'b1);
      mpc_host_i.set_pd(1'b0, 1'b0, 1'b0);
      pin = 1'b1;
      wt(4);
      chk(dpd, 1'b1);
      mpc_host_i.set_pd(1'b0, 1'b1, 1'b0);
      wt(2);
      chk(dpd, 1'b0);
      chk(ctrl.ignore_powerdown_pin, 1'b1);
      pin = 1'b0;
      // Two distinct masks, then select each under register power-down
      mpc_host_i.wr(8'h20, 8'ha5, 1'b0);
      mpc_host_i.wr(8'h21, 8'hf0, 1'b0);
      mpc_host_i.wr(8'h23, 8'h5a, 1'b0);
      mpc_host_i.wr(8'h24, 8'h30, 1'b0);
      rchk(8'h23, 8'h5a);
      mpc_host_i.set_pd(1'b0, 1'b0, 1'b0);
      mpc_host_i.wr(8'h55, 8'h10, 1'b0);
      wt(2);
      chk(pdm, 16'hf0a5);
      chk(ctrl.register_driven_powerdown, 1'b1);
      mpc_host_i.set_pd(1'b0, 1'b0, 1'b1);
      wt(2);
      chk(pdm, 16'h305a);
      chk(ctrl.powerdown_set_choice, 1'b1);
      mpc_host_i.wr(8'h55, 8'h00, 1'b0);
      wt(2);
      chk(pdm, 16'h0000);
      // Every field value, split over three addresses
      for (int v = 0; v < 16; v++) begin
         mpc_host_i.set_perf(4'(v));
         wt(2);
         chk(16'(ctrl.performance_setting_field), 16'(v));
         rchk(8'h39, {2'(v), 6'h00});
         rchk(8'h3a, {1'b0, v[2], 6'h00});
         rchk(8'h56, 8'h00);
      end
      mpc_host_i.wr(8'h4f, 8'h01, 1'b0);
      wt(2);
      chk(ctrl.analog_input_dc_bias_on, 1'b1);
      sref = 1'b1;
      wt(4);
      chk(sout, 1'b1);
      mpc_host_i.wr(8'h53, 8'h40, 1'b0);
      wt(2);
      chk(sout, 1'b0);
      chk(ctrl.sync_reference_ignore, 1'b1);
      mpc_host_i.wr(8'h53, 8'h02, 1'b0);
      wt(2);
      chk(ctrl.sync_reference_high_cm_on, 1'b1);
      chk(sout, 1'b1);
      mpc_host_i.wr(8'h54, 8'h80, 1'b0);
      wt(2);
      chk(sout, 1'b0);
      chk(ctrl.sync_reference_manual_on, 1'b1);
      mpc_host_i.wr(8'h53, 8'h01, 1'b0);
      wt(2);
      chk(sout, 1'b1);
      chk(ctrl.sync_reference_level, 1'b1);
      // Frozen clock enable: a write must leave the bias bit alone
      mpc_host_i.set_ce(1'b0);
      mpc_host_i.wr(8'h4f, 8'h00, 1'b0);
      mpc_host_i.set_ce(1'b1);
      rchk(8'h4f, 8'h01);
      // Second reset in mid-run clears everything
      srst = 1'b1;
      wt(2);
      srst = 1'b0;
      rchk(8'h54, 8'h00);
      chk(16'(ctrl), 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
